// >>> design/hw_breakpoint_watchpoint_unit.sv
// breakpoint and watchpoint unit with apb registers and debug entry logic
`timescale 1ns/1ps
`default_nettype none
module hw_breakpoint_watchpoint_unit (
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [11:0]                        paddr,
	input  wire logic [31:0]                        pwdata,
	output logic [31:0]                             prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic                               host_debug_req,
	input  wire logic                               debug_call_instruction,
	input  wire logic [debug_trigger_pkg::THR_W-1:0] debug_call_thread,
	input  wire logic                               instr_valid,
	input  wire logic [debug_trigger_pkg::THR_W-1:0] instr_thread,
	input  wire logic [31:0]                        instr_pc,
	input  wire logic                               mem_valid,
	input  wire logic                               mem_is_load,
	input  wire logic [debug_trigger_pkg::THR_W-1:0] mem_thread,
	input  wire logic [31:0]                        mem_addr,
	input  wire logic                               res_valid,
	input  wire logic [debug_trigger_pkg::THR_W-1:0] res_thread,
	input  wire logic [31:0]                        res_id,
	output logic                                    debug_irq,
	output logic                                    debug_active
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// true when a register index lies in the group of four at base
	function automatic logic in_group(input logic [7:0] index, input logic [7:0] base);
		in_group = (index[7:2] == base[7:2]);
	endfunction : in_group

	logic [7:0]  reg_idx;
	logic [1:0]  elem;
	logic [3:0]  elem_dec;
	logic        aligned;
	logic        hit_ib_addr;
	logic        hit_ib_ctrl;
	logic        hit_dw_first;
	logic        hit_dw_second;
	logic        hit_dw_ctrl;
	logic        hit_rw_mask;
	logic        hit_rw_value;
	logic        hit_rw_ctrl;
	logic        hit_type;
	logic        hit_data;
	logic        mapped;
	logic        setup_phase;
	logic        access_phase;
	logic        wr_en;

	// index is the word number, element picks one of four triggers
	assign reg_idx  = paddr[9:2];
	assign elem     = reg_idx[1:0];
	assign elem_dec = 4'h1 << elem;
	assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

	assign hit_ib_addr   = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_IBRK_ADDR);
	assign hit_ib_ctrl   = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_IBRK_CTRL);
	assign hit_dw_first  = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_DW_FIRST);
	assign hit_dw_second = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_DW_SECOND);
	assign hit_dw_ctrl   = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_DW_CTRL);
	assign hit_rw_mask   = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_RW_MASK);
	assign hit_rw_value  = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_RW_VALUE);
	assign hit_rw_ctrl   = aligned && in_group(reg_idx, debug_trigger_pkg::IDX_RW_CTRL);
	assign hit_type      = aligned && (reg_idx == debug_trigger_pkg::IDX_IRQ_TYPE);
	assign hit_data      = aligned && (reg_idx == debug_trigger_pkg::IDX_IRQ_DATA);

	assign mapped = hit_ib_addr | hit_ib_ctrl | hit_dw_first | hit_dw_second | hit_dw_ctrl
	              | hit_rw_mask | hit_rw_value | hit_rw_ctrl | hit_type | hit_data;

	// ------------------------------------------------------------
	// apb handshake
	// ------------------------------------------------------------

	// zero wait states: every access completes in its first access cycle
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_en        = access_phase && pwrite && mapped;
	assign pready       = 1'b1;
	assign pslverr      = access_phase && !mapped; // unmapped or misaligned

	// per element write strobes
	logic [3:0] wr_ib_addr;
	logic [3:0] wr_ib_ctrl;
	logic [3:0] wr_dw_first;
	logic [3:0] wr_dw_second;
	logic [3:0] wr_dw_ctrl;
	logic [3:0] wr_rw_mask;
	logic [3:0] wr_rw_value;
	logic [3:0] wr_rw_ctrl;
	logic       wr_type;
	logic       wr_data;

	assign wr_ib_addr   = {4{wr_en & hit_ib_addr}}   & elem_dec;
	assign wr_ib_ctrl   = {4{wr_en & hit_ib_ctrl}}   & elem_dec;
	assign wr_dw_first  = {4{wr_en & hit_dw_first}}  & elem_dec;
	assign wr_dw_second = {4{wr_en & hit_dw_second}} & elem_dec;
	assign wr_dw_ctrl   = {4{wr_en & hit_dw_ctrl}}   & elem_dec;
	assign wr_rw_mask   = {4{wr_en & hit_rw_mask}}   & elem_dec;
	assign wr_rw_value  = {4{wr_en & hit_rw_value}}  & elem_dec;
	assign wr_rw_ctrl   = {4{wr_en & hit_rw_ctrl}}   & elem_dec;
	assign wr_type      = wr_en & hit_type;
	assign wr_data      = wr_en & hit_data;

	// ------------------------------------------------------------
	// trigger registers
	// ------------------------------------------------------------

	logic [31:0] ib_addr_q   [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] ib_ctrl_q   [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] dw_first_q  [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] dw_second_q [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] dw_ctrl_q   [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] rw_mask_q   [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] rw_value_q  [debug_trigger_pkg::NUM_TRIG];
	logic [31:0] rw_ctrl_q   [debug_trigger_pkg::NUM_TRIG];

	for (genvar g = 0; g < debug_trigger_pkg::NUM_TRIG; g++) begin : g_regs
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ib_addr_q[g] <= debug_trigger_pkg::ADDR_RESET;
			end else if (wr_ib_addr[g]) begin
				ib_addr_q[g] <= pwdata;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ib_ctrl_q[g] <= debug_trigger_pkg::CTRL_RESET;
			end else if (wr_ib_ctrl[g]) begin
				ib_ctrl_q[g] <= pwdata & debug_trigger_pkg::IB_CTRL_WMASK;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dw_first_q[g]  <= debug_trigger_pkg::ADDR_RESET;
				dw_second_q[g] <= debug_trigger_pkg::ADDR_RESET;
			end else begin
				if (wr_dw_first[g]) begin
					dw_first_q[g] <= pwdata;
				end
				if (wr_dw_second[g]) begin
					dw_second_q[g] <= pwdata;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dw_ctrl_q[g] <= debug_trigger_pkg::CTRL_RESET;
			end else if (wr_dw_ctrl[g]) begin
				dw_ctrl_q[g] <= pwdata & debug_trigger_pkg::DW_CTRL_WMASK;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rw_mask_q[g]  <= debug_trigger_pkg::ADDR_RESET;
				rw_value_q[g] <= debug_trigger_pkg::ADDR_RESET;
			end else begin
				if (wr_rw_mask[g]) begin
					rw_mask_q[g] <= pwdata;
				end
				if (wr_rw_value[g]) begin
					rw_value_q[g] <= pwdata;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rw_ctrl_q[g] <= debug_trigger_pkg::CTRL_RESET;
			end else if (wr_rw_ctrl[g]) begin
				rw_ctrl_q[g] <= pwdata & debug_trigger_pkg::RW_CTRL_WMASK;
			end
		end
	end

	// ------------------------------------------------------------
	// comparators
	// ------------------------------------------------------------

	trig_cfg_if ib_cfg ();
	trig_cfg_if dw_cfg ();
	trig_cfg_if rw_cfg ();

	// second operand is unused by instruction breakpoints
	assign ib_cfg.first  = ib_addr_q;
	assign ib_cfg.second = '{default: 32'h0};
	assign ib_cfg.ctrl   = ib_ctrl_q;
	assign dw_cfg.first  = dw_first_q;
	assign dw_cfg.second = dw_second_q;
	assign dw_cfg.ctrl   = dw_ctrl_q;
	assign rw_cfg.first  = rw_mask_q;
	assign rw_cfg.second = rw_value_q;
	assign rw_cfg.ctrl   = rw_ctrl_q;

	trigger_match #(
		.KIND    (debug_trigger_pkg::KIND_INSTR)
	) u_instr_match (
		.cfg     (ib_cfg.match),
		.valid   (instr_valid),
		.is_load (1'b0),
		.thread  (instr_thread),
		.value   (instr_pc)
	);

	trigger_match #(
		.KIND    (debug_trigger_pkg::KIND_DATA)
	) u_data_match (
		.cfg     (dw_cfg.match),
		.valid   (mem_valid),
		.is_load (mem_is_load),
		.thread  (mem_thread),
		.value   (mem_addr)
	);

	trigger_match #(
		.KIND    (debug_trigger_pkg::KIND_RES)
	) u_res_match (
		.cfg     (rw_cfg.match),
		.valid   (res_valid),
		.is_load (1'b0),
		.thread  (res_thread),
		.value   (res_id)
	);

	// ------------------------------------------------------------
	// debug entry
	// ------------------------------------------------------------

	debug_trigger_pkg::cause_e             evt_cause;
	logic [debug_trigger_pkg::IDX_W-1:0]   evt_idx;
	logic [7:0]                            evt_thread;
	logic [31:0]                           evt_data;
	logic                                  evt_has_data;
	logic                                  armed;
	logic                                  take;

	cause_encoder u_cause (
		.host_req   (host_debug_req),
		.call       (debug_call_instruction),
		.fire_instr (ib_cfg.fire),
		.fire_data  (dw_cfg.fire),
		.fire_res   (rw_cfg.fire),
		.cause      (evt_cause),
		.idx        (evt_idx)
	);

	assign evt_thread =
		(evt_cause == debug_trigger_pkg::CAUSE_CALL)   ? {5'h0, debug_call_thread} :
		(evt_cause == debug_trigger_pkg::CAUSE_IBRK)   ? {5'h0, instr_thread}      :
		(evt_cause == debug_trigger_pkg::CAUSE_DWATCH) ? {5'h0, mem_thread}        :
		(evt_cause == debug_trigger_pkg::CAUSE_RWATCH) ? {5'h0, res_thread}        :
		                                                 8'h00;

	assign evt_data     = (evt_cause == debug_trigger_pkg::CAUSE_DWATCH) ? mem_addr : res_id;
	assign evt_has_data = (evt_cause == debug_trigger_pkg::CAUSE_DWATCH)
	                   || (evt_cause == debug_trigger_pkg::CAUSE_RWATCH);

	debug_trigger_pkg::state_e state_q;
	debug_trigger_pkg::state_e state_d;

	// writing the type register leaves debug; a same-cycle event still enters it
	assign armed = (state_q == debug_trigger_pkg::ST_RUN) || wr_type;
	assign take  = armed && (evt_cause != debug_trigger_pkg::CAUSE_NONE);

	// run or debug state
	always_comb begin
		case (state_q)
			debug_trigger_pkg::ST_RUN: begin
				state_d = take ? debug_trigger_pkg::ST_DEBUG : debug_trigger_pkg::ST_RUN;
			end
			debug_trigger_pkg::ST_DEBUG: begin
				state_d = (wr_type && !take) ? debug_trigger_pkg::ST_RUN
				                             : debug_trigger_pkg::ST_DEBUG;
			end
			default: begin
				state_d = debug_trigger_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= debug_trigger_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// interrupt record registers
	// ------------------------------------------------------------

	logic [2:0]  cause_q;
	logic [1:0]  idx_q;
	logic [7:0]  thread_q;
	logic [31:0] data_q;
	logic        irq_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q  <= 3'h0;
			idx_q    <= 2'h0;
			thread_q <= 8'h00;
		end else if (take) begin
			cause_q  <= evt_cause;
			idx_q    <= evt_idx;
			thread_q <= evt_thread;
		end else if (wr_type) begin
			cause_q  <= pwdata[2:0];
			idx_q    <= pwdata[debug_trigger_pkg::TYPE_IDX_LSB +: 2];
			thread_q <= pwdata[debug_trigger_pkg::TYPE_THR_LSB +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_q <= 32'h0000_0000;
		end else if (take && evt_has_data) begin
			data_q <= evt_data;
		end else if (wr_data) begin
			data_q <= pwdata;
		end
	end

	// one-cycle interrupt pulse to the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= take;
		end
	end

	assign debug_irq    = irq_q;
	assign debug_active = (state_q == debug_trigger_pkg::ST_DEBUG);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------

	logic [31:0] type_word;
	logic [31:0] rd_word;
	logic [31:0] prdata_q;

	assign type_word = {14'h0, idx_q, thread_q, 5'h0, cause_q};

	assign rd_word = hit_ib_addr   ? ib_addr_q[elem]   :
	                 hit_ib_ctrl   ? ib_ctrl_q[elem]   :
	                 hit_dw_first  ? dw_first_q[elem]  :
	                 hit_dw_second ? dw_second_q[elem] :
	                 hit_dw_ctrl   ? dw_ctrl_q[elem]   :
	                 hit_rw_mask   ? rw_mask_q[elem]   :
	                 hit_rw_value  ? rw_value_q[elem]  :
	                 hit_rw_ctrl   ? rw_ctrl_q[elem]   :
	                 hit_type      ? type_word         :
	                 hit_data      ? data_q            :
	                                 32'h0000_0000;

	// read data is registered in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	assign prdata = prdata_q;

endmodule : hw_breakpoint_watchpoint_unit
`default_nettype wire

// >>> pkg/debug_trigger_pkg.sv
// constants and types shared by the hardware breakpoint and watchpoint unit
//
// Operation
// - instruction breakpoint fires on program counter match
// - four independent instruction breakpoints with own registers
// - eight-bit per-thread mask, resets to zero
// - bit 1 selects equal or not-equal compare
// - bit 0 enables each trigger, resets clear
// - four data watchpoints with first address
// - each data watchpoint holds second address
// - each data watchpoint has own control register
// - bit 2 lets data watchpoint fire on loads
// - bit 1 combines conditions: and, or
// - four resource watchpoints with 32-bit mask
// - resource watchpoint compare value, masked match
// - each resource watchpoint has own control register
// - bit 1 picks condition A or B
// - record three-bit cause code of interrupt
// - record eight-bit number of causing thread
// - capture access address or resource identifier
package debug_trigger_pkg;
	localparam int unsigned NUM_TRIG   = 4;
	localparam int unsigned NUM_THREAD = 8;
	localparam int unsigned THR_W      = 3;
	localparam int unsigned IDX_W      = 2;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_IBRK_ADDR   = 8'h30;
	localparam logic [7:0] IDX_IBRK_CTRL   = 8'h40;
	localparam logic [7:0] IDX_DW_FIRST    = 8'h50;
	localparam logic [7:0] IDX_DW_SECOND   = 8'h60;
	localparam logic [7:0] IDX_DW_CTRL     = 8'h70;
	localparam logic [7:0] IDX_RW_MASK     = 8'h80;
	localparam logic [7:0] IDX_RW_VALUE    = 8'h90;
	localparam logic [7:0] IDX_RW_CTRL     = 8'h9c;
	localparam logic [7:0] IDX_IRQ_TYPE    = 8'h15;
	localparam logic [7:0] IDX_IRQ_DATA    = 8'h16;
	// control register fields
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_SEL_BIT   = 1;
	localparam int unsigned CTRL_LOAD_BIT  = 2;
	localparam int unsigned CTRL_THR_LSB   = 16;
	localparam logic [31:0] IB_CTRL_WMASK  = 32'h00ff_0003;
	localparam logic [31:0] DW_CTRL_WMASK  = 32'h00ff_0007;
	localparam logic [31:0] RW_CTRL_WMASK  = 32'h00ff_0003;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
	// interrupt type register fields
	localparam int unsigned TYPE_THR_LSB   = 8;
	localparam int unsigned TYPE_IDX_LSB   = 16;
	// trigger kinds
	localparam int unsigned KIND_INSTR     = 0;
	localparam int unsigned KIND_DATA      = 1;
	localparam int unsigned KIND_RES       = 2;
	typedef enum logic [2:0] {
		CAUSE_NONE   = 3'h0,
		CAUSE_HOST   = 3'h1,
		CAUSE_CALL   = 3'h2,
		CAUSE_IBRK   = 3'h3,
		CAUSE_DWATCH = 3'h4,
		CAUSE_RWATCH = 3'h5
	} cause_e;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b01,
		ST_DEBUG = 2'b10
	} state_e;
endpackage : debug_trigger_pkg

// >>> pkg/trig_cfg_if.sv
// configuration and fire flags of one group of four triggers
`timescale 1ns/1ps
`default_nettype none
interface trig_cfg_if;
	logic [31:0]                              first  [debug_trigger_pkg::NUM_TRIG];
	logic [31:0]                              second [debug_trigger_pkg::NUM_TRIG];
	logic [31:0]                              ctrl   [debug_trigger_pkg::NUM_TRIG];
	logic [debug_trigger_pkg::NUM_TRIG-1:0]   fire;
	modport regs  (output first, output second, output ctrl, input fire);
	modport match (input first, input second, input ctrl, output fire);
endinterface : trig_cfg_if
`default_nettype wire

// >>> design/trigger_match.sv
// comparators for one group of four triggers of a given kind
`timescale 1ns/1ps
`default_nettype none
module trigger_match #(
	parameter int unsigned KIND = 0
) (
	trig_cfg_if.match                          cfg,
	input  wire logic                          valid,
	input  wire logic                          is_load,
	input  wire logic [debug_trigger_pkg::THR_W-1:0] thread,
	input  wire logic [31:0]                   value
);
	for (genvar g = 0; g < debug_trigger_pkg::NUM_TRIG; g++) begin : g_trig
		logic [31:0] c;
		logic        en;
		logic        thr_ok;
		logic        sel;
		logic        cond_a;
		logic        cond_b;
		logic        cond;
		logic        load_ok;
		assign c  = cfg.ctrl[g];
		assign en = c[debug_trigger_pkg::CTRL_EN_BIT];
		assign thr_ok = c[debug_trigger_pkg::CTRL_THR_LSB + 32'(thread)];
		assign sel = c[debug_trigger_pkg::CTRL_SEL_BIT];
		if (KIND == debug_trigger_pkg::KIND_INSTR) begin : g_instr
			assign cond_a  = (value == cfg.first[g]);
			assign cond_b  = 1'b0;
			assign cond    = sel ? !cond_a : cond_a;
			assign load_ok = 1'b1;
		end else if (KIND == debug_trigger_pkg::KIND_DATA) begin : g_data
			assign cond_a  = (value == cfg.first[g]);
			assign cond_b  = (value == cfg.second[g]);
			assign cond    = sel ? (cond_a | cond_b) : (cond_a & cond_b);
			assign load_ok = !is_load || c[debug_trigger_pkg::CTRL_LOAD_BIT];
		end else begin : g_res
			assign cond_a  = ((value & cfg.first[g]) == (cfg.second[g] & cfg.first[g]));
			assign cond_b  = !cond_a;
			assign cond    = sel ? cond_b : cond_a;
			assign load_ok = 1'b1;
		end
		assign cfg.fire[g] = valid & en & thr_ok & cond & load_ok;
	end
endmodule : trigger_match
`default_nettype wire

// >>> design/cause_encoder.sv
// picks the cause and trigger index of a debug interrupt by fixed priority
`timescale 1ns/1ps
`default_nettype none
module cause_encoder (
	input  wire logic                          host_req,
	input  wire logic                          call,
	input  wire logic [3:0]                    fire_instr,
	input  wire logic [3:0]                    fire_data,
	input  wire logic [3:0]                    fire_res,
	output debug_trigger_pkg::cause_e          cause,
	output logic [debug_trigger_pkg::IDX_W-1:0] idx
);
	// lowest set bit of a four-bit fire vector
	function automatic logic [1:0] lowest(input logic [3:0] v);
		lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
	endfunction : lowest

	assign cause = host_req      ? debug_trigger_pkg::CAUSE_HOST   :
	               call          ? debug_trigger_pkg::CAUSE_CALL   :
	               (|fire_instr) ? debug_trigger_pkg::CAUSE_IBRK   :
	               (|fire_data)  ? debug_trigger_pkg::CAUSE_DWATCH :
	               (|fire_res)   ? debug_trigger_pkg::CAUSE_RWATCH :
	                               debug_trigger_pkg::CAUSE_NONE;
	assign idx = (cause == debug_trigger_pkg::CAUSE_IBRK)   ? lowest(fire_instr) :
	             (cause == debug_trigger_pkg::CAUSE_DWATCH) ? lowest(fire_data)  :
	             (cause == debug_trigger_pkg::CAUSE_RWATCH) ? lowest(fire_res)   :
	                                                          2'h0;
endmodule : cause_encoder
`default_nettype wire

// >>> sim/hw_bpwp_sva.sv
// port assertions for the breakpoint and watchpoint unit
`timescale 1ns/1ps
`default_nettype none
module hw_bpwp_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        host_debug_req,
	input wire logic        debug_call_instruction,
	input wire logic        instr_valid,
	input wire logic        mem_valid,
	input wire logic        res_valid,
	input wire logic        debug_irq,
	input wire logic        debug_active
);
	// access phase, exit write and any core event
	wire logic acc     = psel && penable;
	wire logic type_wr = acc && pwrite && paddr == 12'h054;
	wire logic any_ev  = host_debug_req || debug_call_instruction || instr_valid
		|| mem_valid || res_valid;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (acc |-> pready)
		else $error("access without ready");
	a_bad_align: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0)
		else $error("misaligned access not refused");
	a_host_entry: assert property (!debug_active && host_debug_req |=> debug_irq && debug_active)
		else $error("host request not taken");
	a_call_entry: assert property (!debug_active && debug_call_instruction |=> debug_irq)
		else $error("debug call not taken");
	a_irq_pulse: assert property (debug_irq && !type_wr |=> !debug_irq)
		else $error("interrupt longer than one cycle");
	a_irq_cause: assert property (debug_irq |-> $past(any_ev))
		else $error("interrupt without event");
	a_held_debug: assert property (debug_active && !type_wr |=> debug_active)
		else $error("debug mode left without write");
	a_quiet_debug: assert property (debug_active && !type_wr |=> !debug_irq)
		else $error("event taken while in debug");
	a_exit_write: assert property (type_wr && !any_ev |=> !debug_active)
		else $error("type write did not exit debug");
endmodule : hw_bpwp_sva
bind hw_breakpoint_watchpoint_unit hw_bpwp_sva hw_bpwp_sva_i (.*);
`default_nettype wire

// >>> sim/core_model.sv
// core pipeline model that issues one-cycle events to the unit
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        pclk,
	output logic             host_debug_req,
	output logic             debug_call_instruction,
	output logic [2:0]       debug_call_thread,
	output logic             instr_valid,
	output logic [2:0]       instr_thread,
	output logic [31:0]      instr_pc,
	output logic             mem_valid,
	output logic             mem_is_load,
	output logic [2:0]       mem_thread,
	output logic [31:0]      mem_addr,
	output logic             res_valid,
	output logic [2:0]       res_thread,
	output logic [31:0]      res_id
);
	// idle core at time zero
	initial begin
		{host_debug_req, debug_call_instruction, res_valid, mem_valid, instr_valid} = 5'h00;
		{debug_call_thread, instr_thread, mem_thread, res_thread, mem_is_load} = 13'h0;
		{instr_pc, mem_addr, res_id} = 96'h0;
	end
	// one event cycle, then data lines show the inverse so stale values never match
	task automatic ev(input logic [4:0] k, input logic [2:0] t, input logic [31:0] v,
		input logic ld);
		@(posedge pclk);
		{host_debug_req, debug_call_instruction, res_valid, mem_valid, instr_valid} <= k;
		{debug_call_thread, instr_thread, mem_thread, res_thread} <= {4{t}};
		{instr_pc, mem_addr, res_id} <= {3{v}};
		mem_is_load <= ld;
		@(posedge pclk);
		{host_debug_req, debug_call_instruction, res_valid, mem_valid, instr_valid} <= 5'h00;
		{instr_pc, mem_addr, res_id} <= {3{~v}};
	endtask : ev
endmodule : core_model
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the breakpoint and watchpoint unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic [11:0] a1; logic [31:0] v1; logic [11:0] a2; logic [31:0] v2;
		logic [11:0] a3; logic [31:0] v3; logic [4:0] k; logic [2:0] t; logic [31:0] v;
		logic ld; logic [31:0] ty;} row_s;
	logic             pclk, presetn, psel, penable, pwrite, err_v;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, rd_v;
	wire logic [31:0] prdata, instr_pc, mem_addr, res_id;
	wire logic        pready, pslverr, debug_irq, debug_active, host_debug_req;
	wire logic        debug_call_instruction, instr_valid, mem_valid, mem_is_load, res_valid;
	wire logic [2:0]  debug_call_thread, instr_thread, mem_thread, res_thread;
	int               num_errors, cmp_count, n;
	row_s rows [10] = '{
		'{12'h0c4,32'h1000,12'h0c4,32'h1000,12'h104,32'h20001,5'h01,3'd1,32'h1000,1'b0,32'h10103},
		'{12'h0c4,32'h1000,12'h0c4,32'h1000,12'h104,32'h20001,5'h01,3'd2,32'h1000,1'b0,32'h0},
		'{12'h0c8,32'h1000,12'h0c8,32'h1000,12'h108,32'h40003,5'h01,3'd2,32'h2000,1'b0,32'h20203},
		'{12'h0c0,32'h0,12'h0c0,32'h0,12'h100,32'hff0000,5'h01,3'd0,32'h0,1'b0,32'h0},
		'{12'h140,32'h4000,12'h180,32'h4000,12'h1c0,32'h10001,5'h02,3'd0,32'h4000,1'b0,32'h4},
		'{12'h14c,32'h5000,12'h18c,32'h6000,12'h1cc,32'h800003,5'h02,3'd7,32'h6000,1'b1,32'h0},
		'{12'h14c,32'h5000,12'h18c,32'h6000,12'h1cc,32'h800007,5'h02,3'd7,32'h6000,1'b1,32'h30704},
		'{12'h144,32'h7000,12'h184,32'h7004,12'h1c4,32'h10001,5'h02,3'd0,32'h7000,1'b0,32'h0},
		'{12'h200,32'hff00,12'h240,32'h1200,12'h270,32'h10001,5'h04,3'd0,32'habcd12ef,1'b0,32'h5},
		'{12'h208,32'hff,12'h248,32'h34,12'h278,32'h100003,5'h04,3'd4,32'h35,1'b0,32'h20405}};
	logic [11:0] bad [3] = '{12'h004, 12'h0c2, 12'h400};
	logic [4:0]  ks [3]  = '{5'h01, 5'h11, 5'h09};
	logic [31:0] ts [3]  = '{32'h303, 32'h1, 32'h302};
	hw_breakpoint_watchpoint_unit hw_breakpoint_watchpoint_unit_i (.*);
	core_model core_model_i (.*);
	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t word %h expected %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_bit(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t flag %b expected %b", $time, g, e);
		end
	endtask : chk_bit
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			wrap_up();
		end
		{rd_v, err_v} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a1, rows[i].v1);
			apb(1'b1, rows[i].a2, rows[i].v2);
			apb(1'b1, rows[i].a3, rows[i].v3);
			core_model_i.ev(rows[i].k, rows[i].t, rows[i].v, rows[i].ld);
			@(negedge pclk);
			chk_bit(debug_irq, rows[i].ty != 32'h0);
			if (rows[i].ty != 32'h0) begin
				apb(1'b0, 12'h054, 32'h0);
				chk_word(rd_v, rows[i].ty);
				apb(1'b0, 12'h058, 32'h0);
				if (rows[i].ty[2]) chk_word(rd_v, rows[i].v);
				apb(1'b1, 12'h054, 32'h0);
			end
			apb(1'b1, rows[i].a3, 32'h0);
		end
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h1c0, 32'h0);
		chk_word(rd_v, 32'h0);
		foreach (bad[i]) begin
			apb(1'b1, bad[i], 32'hffffffff);
			chk_bit(err_v, 1'b1);
		end
		apb(1'b1, 12'h1c0, 32'hffffffff);
		apb(1'b0, 12'h1c0, 32'h0);
		chk_word(rd_v, 32'h00ff0007);
		apb(1'b1, 12'h104, 32'hffffffff);
		apb(1'b0, 12'h104, 32'h0);
		chk_word(rd_v, 32'h00ff0003);
		apb(1'b1, 12'h0c0, 32'h100);
		apb(1'b1, 12'h0c4, 32'h100);
		apb(1'b1, 12'h100, 32'h80001);
		apb(1'b1, 12'h104, 32'h80001);
		for (int j = 0; j < 3; j++) begin
			core_model_i.ev(ks[j], 3'd3, 32'h100, 1'b0);
			apb(1'b0, 12'h054, 32'h0);
			chk_word(rd_v, ts[j]);
			core_model_i.ev(5'h01, 3'd3, 32'h100, 1'b0);
			@(negedge pclk);
			chk_bit(debug_irq, 1'b0);
			apb(1'b1, 12'h054, 32'h0);
		end
		wrap_up();
	end
endmodule : tb
`default_nettype wire
